// [src/led_seq.v]
// Chosen here: the AXI4-Lite register port and the register addresses.
`include "led_seq_map.vh"
module led_seq #(
    parameter STRINGS    = 8,
    parameter CYC_SWITCH = `CYC_SWITCH,
    parameter CYC_CHECK  = `CYC_CHECK,
    parameter CYC_BOOST  = `CYC_BOOST,
    parameter CYC_SHORT  = `CYC_SHORT,
    parameter CYC_OC     = `CYC_OC
) (
    input  wire               aclk,
    input  wire               aresetn,
    input  wire               clk_en,
    input  wire               enable_pin,
    input  wire               mode_freq_select_pin,
    input  wire               vcc_uvlo,
    input  wire               in_uvlo,
    input  wire               ovp_low_trip,
    input  wire               ovp_high_trip,
    input  wire               current_limit,
    input  wire               thermal_fault,
    input  wire               external_dimming_input,
    input  wire [STRINGS-1:0] string_feedback_input,
    input  wire [STRINGS-1:0] string_short_input,
    output reg                ldo_on,
    output reg                fault_sink_on,
    output reg                check_pullup,
    output reg                boost_on,
    output wire               power_switch_en,
    output reg  [STRINGS-1:0] string_enable,
    output wire [STRINGS-1:0] string_drive,
    input  wire [11:0]        s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output wire               s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output wire               s_axi_wready,
    output reg  [1:0]         s_axi_bresp,
    output reg                s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [11:0]        s_axi_araddr,
    input  wire               s_axi_arvalid,
    output wire               s_axi_arready,
    output reg  [31:0]        s_axi_rdata,
    output reg  [1:0]         s_axi_rresp,
    output reg                s_axi_rvalid,
    input  wire               s_axi_rready
);

localparam S_OFF    = 3'd0;
localparam S_SWITCH = 3'd1;
localparam S_CHECK  = 3'd2;
localparam S_BOOST  = 3'd3;
localparam S_RUN    = 3'd4;
localparam S_FAULT  = 3'd5;

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers.

localparam NS = 8 + 2 * STRINGS;
wire [NS-1:0] raw_in = {enable_pin, mode_freq_select_pin, vcc_uvlo, in_uvlo,
                        ovp_low_trip, ovp_high_trip, current_limit, thermal_fault,
                        string_feedback_input, string_short_input};
reg  [NS-1:0] sync_a;
reg  [NS-1:0] sync_b;
reg           dim_a;
reg           dim_b;

always @(posedge aclk) begin
    if (!aresetn) begin
        sync_a <= {NS{1'b0}};
        sync_b <= {NS{1'b0}};
    end else if (clk_en) begin
        sync_a <= raw_in;
        sync_b <= sync_a;
    end
end

////////////////////////////////////////////////////////////////////////////////
// The dimming pin reaches the short timer through its own two flops.
// The string drive path itself stays direct to keep short on-pulses.

always @(posedge aclk) begin
    if (!aresetn) begin
        dim_a <= 1'b0;
        dim_b <= 1'b0;
    end else if (clk_en) begin
        dim_a <= external_dimming_input;
        dim_b <= dim_a;
    end
end

wire               en_s    = sync_b[NS-1];
wire               msel_s  = sync_b[NS-2];
wire               vuv_s   = sync_b[NS-3];
wire               iuv_s   = sync_b[NS-4];
wire               ovl_s   = sync_b[NS-5];
wire               ovh_s   = sync_b[NS-6];
wire               ilim_s  = sync_b[NS-7];
wire               tsd_s   = sync_b[NS-8];
wire [STRINGS-1:0] fb_s    = sync_b[2*STRINGS-1:STRINGS];
wire [STRINGS-1:0] short_s = sync_b[STRINGS-1:0];

////////////////////////////////////////////////////////////////////////////////
// Registers and mode latch.

reg  [7:0]         bright;
reg  [2:0]         ctrl;
reg  [7:0]         status;
reg  [STRINGS-1:0] in_use;
reg  [STRINGS-1:0] open_flag;
reg  [STRINGS-1:0] short_flag;
reg                mode_set;
reg                mode_pwm;
reg                on_req;
reg                en_prev;
reg  [2:0]         state;
reg  [2:0]         next_state;
reg  [22:0]        phase_cnt;
reg  [22:0]        oc_cnt;

wire on_bit   = ctrl[`CTRL_ON_BIT];
wire wake_pin = en_s & ~en_prev;
wire first_en = !mode_set && (en_s || on_bit);
wire wake     = mode_set ? (mode_pwm ? wake_pin : on_bit) : first_en;
wire stop_req = mode_pwm ? !en_s : !on_bit;
wire in_uv_on = !mode_pwm && iuv_s;
wire all_open = (|in_use) && ((open_flag | short_flag) == in_use);
wire crit     = ovh_s || tsd_s || (oc_cnt >= CYC_OC[22:0]);
wire running  = (state != S_OFF) && (state != S_FAULT);

always @(posedge aclk) begin
    if (!aresetn) begin
        mode_set <= 1'b0;
        mode_pwm <= 1'b0;
        en_prev  <= 1'b0;
    end else if (clk_en) begin
        en_prev <= en_s;
        if (first_en && !vuv_s) begin
            mode_set <= 1'b1;
            mode_pwm <= !msel_s;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Startup and shutdown sequencer.

always @* begin
    next_state = state;
    case (state)
        S_OFF: begin
            if (wake && !vuv_s)
                next_state = S_SWITCH;
        end
        S_SWITCH: begin
            if (phase_cnt >= CYC_SWITCH[22:0] - 23'd1)
                next_state = S_CHECK;
        end
        S_CHECK: begin
            if (phase_cnt >= CYC_CHECK[22:0] - 23'd1)
                next_state = S_BOOST;
        end
        S_BOOST: begin
            if (phase_cnt >= CYC_BOOST[22:0] - 23'd1)
                next_state = S_RUN;
        end
        S_RUN: next_state = S_RUN;
        S_FAULT: begin
            if (mode_pwm ? wake_pin : on_req)
                next_state = S_SWITCH;
        end
        default: next_state = S_OFF;
    endcase
    if (running && crit)
        next_state = S_FAULT;
    else if (running && (vuv_s || stop_req))
        next_state = S_OFF;
end

always @(posedge aclk) begin
    if (!aresetn) begin
        state     <= S_OFF;
        phase_cnt <= 23'd0;
        oc_cnt    <= 23'd0;
    end else if (clk_en) begin
        state <= next_state;
        if (next_state != state || state == S_RUN || !running)
            phase_cnt <= 23'd0;
        else
            phase_cnt <= phase_cnt + 23'd1;
        if (running && ilim_s)
            oc_cnt <= oc_cnt + 23'd1;
        else
            oc_cnt <= 23'd0;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        ldo_on        <= 1'b0;
        fault_sink_on <= 1'b0;
        check_pullup  <= 1'b0;
        boost_on      <= 1'b0;
    end else if (clk_en) begin
        ldo_on        <= (next_state != S_OFF) && (next_state != S_FAULT);
        fault_sink_on <= (next_state != S_OFF) && (next_state != S_FAULT);
        check_pullup  <= (next_state == S_CHECK);
        boost_on      <= (next_state == S_BOOST || next_state == S_RUN)
                         && !in_uv_on && !all_open;
    end
end

assign power_switch_en = boost_on && !ovl_s;

////////////////////////////////////////////////////////////////////////////////
// Per-string scan, open and short handling.

genvar gi;
generate
    for (gi = 0; gi < STRINGS; gi = gi + 1) begin : g_str
        reg [22:0] sh_cnt;
        always @(posedge aclk) begin
            if (!aresetn) begin
                in_use[gi]     <= 1'b0;
                open_flag[gi]  <= 1'b0;
                short_flag[gi] <= 1'b0;
                sh_cnt         <= 23'd0;
            end else if (clk_en) begin
                // Flags clear as a new startup begins, together with the status.
                if (state != S_SWITCH && next_state == S_SWITCH) begin
                    open_flag[gi]  <= 1'b0;
                    short_flag[gi] <= 1'b0;
                end
                if (state == S_CHECK && next_state == S_BOOST)
                    in_use[gi] <= fb_s[gi];
                if (state == S_RUN && in_use[gi] && !fb_s[gi])
                    open_flag[gi] <= 1'b1;
                if (state == S_RUN && in_use[gi] && short_s[gi]
                    && dim_b) begin
                    if (sh_cnt >= CYC_SHORT[22:0] - 23'd1)
                        short_flag[gi] <= 1'b1;
                    else
                        sh_cnt <= sh_cnt + 23'd1;
                end else if (state != S_RUN || !short_s[gi]) begin
                    sh_cnt <= 23'd0;
                end
            end
        end
        always @(posedge aclk) begin
            if (!aresetn)
                string_enable[gi] <= 1'b0;
            else if (clk_en)
                string_enable[gi] <= (next_state == S_RUN || next_state == S_BOOST)
                                     && in_use[gi] && !open_flag[gi]
                                     && !short_flag[gi];
        end
    end
endgenerate

assign string_drive = string_enable & {STRINGS{external_dimming_input}};

////////////////////////////////////////////////////////////////////////////////
// Status register.

always @(posedge aclk) begin
    if (!aresetn) begin
        status <= 8'h00;
    end else if (clk_en) begin
        if (state != S_SWITCH && next_state == S_SWITCH)
            status <= 8'h00;
        else begin
            if (!mode_pwm && |open_flag)
                status[`ST_OPEN_BIT] <= 1'b1;
            if (!mode_pwm && |short_flag)
                status[`ST_SHORT_BIT] <= 1'b1;
            if (running && ovh_s)
                status[`ST_OVP_BIT] <= 1'b1;
            if (running && crit && !ovh_s)
                status[`ST_OC_BIT] <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave.

reg         aw_held;
reg         w_held;
reg  [11:0] aw_addr;
reg  [31:0] w_data;
reg  [3:0]  w_strb;

assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready  = !w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire do_write = aw_held && w_held && !s_axi_bvalid;
wire wr_ok    = (aw_addr == `ADDR_BRIGHT) || (aw_addr == `ADDR_CTRL);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        aw_addr      <= 12'h000;
        w_data       <= 32'h00000000;
        w_strb       <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= 2'b00;
        bright       <= `RST_BRIGHT;
        ctrl         <= `RST_CTRL;
    end else if (clk_en) begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            if (w_strb[0] && !mode_pwm) begin
                if (aw_addr == `ADDR_BRIGHT)
                    bright <= w_data[7:0];
                if (aw_addr == `ADDR_CTRL)
                    ctrl <= w_data[2:0];
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// A fresh write of one to the on bit is what ends a serial fault shutdown.
always @(posedge aclk) begin
    if (!aresetn)
        on_req <= 1'b0;
    else if (clk_en)
        on_req <= do_write && (aw_addr == `ADDR_CTRL) && w_strb[0] && !mode_pwm
                  && w_data[`CTRL_ON_BIT];
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h00000000;
        s_axi_rresp  <= 2'b00;
    end else if (clk_en) begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
                `ADDR_BRIGHT:  s_axi_rdata <= {24'h000000, bright};
                `ADDR_CTRL:    s_axi_rdata <= {29'h00000000, ctrl};
                `ADDR_STATUS:  s_axi_rdata <= {21'h000000, state, mode_pwm,
                                               status[6:0]};
                `ADDR_STRINGS: s_axi_rdata <= {8'h00, short_flag, open_flag, in_use};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // led_seq

// [src/led_seq_map.vh]
`ifndef LED_SEQ_MAP_VH
`define LED_SEQ_MAP_VH
`define CLK_HZ          50000000
`define T_SWITCH_US     100
`define T_CHECK_US      1000
`define T_BOOST_US      4000
`define T_SHORT_US      2000
`define T_OC_US         128
`define CYC_SWITCH      (`T_SWITCH_US * (`CLK_HZ / 1000000))
`define CYC_CHECK       (`T_CHECK_US * (`CLK_HZ / 1000000))
`define CYC_BOOST       (`T_BOOST_US * (`CLK_HZ / 1000000))
`define CYC_SHORT       (`T_SHORT_US * (`CLK_HZ / 1000000))
`define CYC_OC          (`T_OC_US * (`CLK_HZ / 1000000))
`define ADDR_BRIGHT     12'h000
`define ADDR_CTRL       12'h004
`define ADDR_STATUS     12'h008
`define ADDR_STRINGS    12'h00c
`define RST_BRIGHT      8'hff
`define RST_CTRL        3'h0
`define CTRL_ON_BIT     0
`define ST_OPEN_BIT     4
`define ST_SHORT_BIT    5
`define ST_OVP_BIT      0
`define ST_OC_BIT       1
`define ST_MODE_BIT     7
`endif

// [sim/led_array.sv]
module led_array (
    input  wire logic       check_pullup,
    input  wire logic [7:0] string_drive,
    input  wire logic [7:0] connected,
    input  wire logic [7:0] open_f,
    input  wire logic [7:0] short_f,
    output wire logic [7:0] string_feedback_input,
    output wire logic [7:0] string_short_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // A grounded string reads low; a broken string falls low outside the scan.
    assign string_feedback_input = check_pullup ? connected : connected & ~open_f;
    // The short comparator trips only while the string is driven on.
    assign string_short_input = short_f & string_drive;
endmodule // led_array

// [sim/led_seq_checker.sv]
module led_seq_checker #(
    parameter STRINGS    = 8,
    parameter CYC_SWITCH = 4,
    parameter CYC_CHECK  = 8,
    parameter CYC_BOOST  = 8
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               vcc_uvlo,
    input wire logic               ovp_low_trip,
    input wire logic               ovp_high_trip,
    input wire logic               external_dimming_input,
    input wire logic               ldo_on,
    input wire logic               fault_sink_on,
    input wire logic               check_pullup,
    input wire logic               boost_on,
    input wire logic               power_switch_en,
    input wire logic [STRINGS-1:0] string_enable,
    input wire logic [STRINGS-1:0] string_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    int phase_cnt;
    // Counts cycles since the regulator came on.
    always_ff @(posedge aclk) begin
        if (!aresetn || !ldo_on)
            phase_cnt <= 0;
        else
            phase_cnt <= phase_cnt + 1;
    end
    ////////////////////////////////////////
    property p_reset;
        $rose(aresetn) |-> !ldo_on && !boost_on && !check_pullup && string_enable == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs on after reset");
    property p_uvlo;
        vcc_uvlo [*5] |-> !$rose(ldo_on);
    endproperty
    a_uvlo: assert property (p_uvlo) else $error("start under lockout");
    property p_switch;
        $rose(check_pullup) |-> phase_cnt == CYC_SWITCH && fault_sink_on;
    endproperty
    a_switch: assert property (p_switch) else $error("switch phase length");
    property p_check;
        $fell(check_pullup) |-> boost_on && phase_cnt == CYC_SWITCH + CYC_CHECK;
    endproperty
    a_check: assert property (p_check) else $error("check phase length");
    property p_off;
        !ldo_on |-> !fault_sink_on && !boost_on && !check_pullup && string_enable == '0;
    endproperty
    a_off: assert property (p_off) else $error("function on while off");
    property p_ovp_gate;
        power_switch_en == (boost_on && !$past(ovp_low_trip, 2));
    endproperty
    a_ovp_gate: assert property (p_ovp_gate) else $error("switch gate wrong");
    property p_ovp_stop;
        $rose(ovp_high_trip) && boost_on |-> ##[1:5] !ldo_on && !boost_on;
    endproperty
    a_ovp_stop: assert property (p_ovp_stop) else $error("no shutdown");
    property p_drive;
        string_drive == (string_enable & {STRINGS{external_dimming_input}});
    endproperty
    a_drive: assert property (p_drive) else $error("string drive wrong");
    property p_mask;
        boost_on && $past(boost_on) && phase_cnt <= CYC_SWITCH + CYC_CHECK + CYC_BOOST
            |-> ($past(string_enable) & ~string_enable) == '0;
    endproperty
    a_mask: assert property (p_mask) else $error("string dropped in soft start");
    c_start: cover property ($rose(boost_on));
    c_drop: cover property (boost_on && $past(string_enable) != string_enable);
    c_ovp: cover property ($rose(ovp_high_trip) && boost_on);
endmodule // led_seq_checker

bind led_seq led_seq_checker #(
    .STRINGS(STRINGS), .CYC_SWITCH(CYC_SWITCH), .CYC_CHECK(CYC_CHECK), .CYC_BOOST(CYC_BOOST)
) chk_u (
    .aclk, .aresetn, .vcc_uvlo, .ovp_low_trip, .ovp_high_trip, .external_dimming_input,
    .ldo_on, .fault_sink_on, .check_pullup, .boost_on, .power_switch_en, .string_enable,
    .string_drive
);

// [sim/led_seq_bench.sv]
module led_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CS = 4, CC = 8, CB = 8, CSH = 4, COC = 4;
    logic        aclk = 0, aresetn = 0, clk_en = 1, enable_pin = 0, mode_freq_select_pin = 1;
    logic        vcc_uvlo = 1, in_uvlo = 0, ovp_low_trip = 0, ovp_high_trip = 0;
    logic        current_limit = 0, thermal_fault = 0, external_dimming_input = 1;
    logic [7:0]  string_feedback_input, string_short_input, string_enable, string_drive;
    logic [7:0]  connected = 8'hb7, open_f = 0, short_f = 0;
    logic        ldo_on, fault_sink_on, check_pullup, boost_on, power_switch_en;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          fail_count = 0, check_count = 0;
    always #10 aclk = ~aclk;
    led_seq #(.CYC_SWITCH(CS), .CYC_CHECK(CC), .CYC_BOOST(CB), .CYC_SHORT(CSH), .CYC_OC(COC))
    dut_u (
        .aclk, .aresetn, .clk_en, .enable_pin, .mode_freq_select_pin, .vcc_uvlo, .in_uvlo,
        .ovp_low_trip, .ovp_high_trip, .current_limit, .thermal_fault,
        .external_dimming_input, .string_feedback_input, .string_short_input, .ldo_on,
        .fault_sink_on, .check_pullup, .boost_on, .power_switch_en, .string_enable,
        .string_drive, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    led_array arr_u (.check_pullup, .string_drive, .connected, .open_f, .short_f,
        .string_feedback_input, .string_short_input);
    ////////////////////////////////////////
    task automatic tick(int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic chk(logic [31:0] g, logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One bus transfer; channels are released only at the edge that takes them.
    task automatic bus(bit w, logic [11:0] a, logic [31:0] d);
        bit ap, dp, b, x, y;
        @(posedge aclk);
        ap = 1;
        dp = w;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(negedge aclk);
            x = w ? s_axi_awready : s_axi_arready;
            y = s_axi_wready;
            b = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge aclk);
            if (ap && x) begin
                ap = 0;
                s_axi_awvalid <= 0;
                s_axi_arvalid <= 0;
            end
            if (dp && y) begin
                dp = 0;
                s_axi_wvalid <= 0;
            end
        end while (!b);
        s_axi_bready <= 0;
        s_axi_rready <= 0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        bus(1, a, d);
        chk(r, 2'h0);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        bus(0, a, 0);
        chk(q, e);
    endtask
    // Waits a bounded time for the boost converter, then lets soft start finish.
    task automatic up;
        int n;
        n = 0;
        while (boost_on !== 1'h1 && n < 100) begin
            @(negedge aclk);
            n++;
        end
        chk(boost_on, 1'h1);
        tick(CB + 4);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #100us;
        fail_count++;
        finish_test;
    end
    initial begin
        tick(5);
        aresetn <= 1'h1;
        rd(12'h000, 32'hff);
        rd(12'h004, 32'h0);
        rd(12'h008, 32'h0);
        rd(12'h010, 32'h0);
        chk(r, 2'h2);
        wr(12'h004, 32'h1);
        tick(20);
        chk(ldo_on, 1'h0);
        vcc_uvlo <= 1'h0;
        wr(12'h004, 32'h0);
        wr(12'h004, 32'h1);
        up;
        chk(string_enable, connected);
        rd(12'h00c, {24'h0, connected});
        rd(12'h008, 32'h400);
        enable_pin <= 1'h1;
        tick(6);
        enable_pin <= 1'h0;
        tick(6);
        chk(boost_on, 1'h1);
        ovp_low_trip <= 1'h1;
        tick(4);
        chk(power_switch_en, 1'h0);
        ovp_low_trip <= 1'h0;
        tick(4);
        chk(power_switch_en, 1'h1);
        external_dimming_input <= 1'h0;
        tick(1);
        chk(string_drive, 8'h0);
        external_dimming_input <= 1'h1;
        open_f <= 8'h01;
        tick(10);
        chk(string_enable, 8'hb6);
        short_f <= 8'h02;
        tick(CSH + 8);
        chk(string_enable, 8'hb4);
        rd(12'h008, 32'h430);
        rd(12'h00c, 32'h201b7);
        wr(12'h004, 32'h0);
        tick(4);
        chk(ldo_on, 1'h0);
        open_f <= 8'h0;
        short_f <= 8'h0;
        wr(12'h004, 32'h1);
        up;
        rd(12'h008, 32'h400);
        ovp_high_trip <= 1'h1;
        tick(10);
        ovp_high_trip <= 1'h0;
        chk(ldo_on, 1'h0);
        rd(12'h008, 32'h501);
        wr(12'h004, 32'h1);
        up;
        rd(12'h008, 32'h400);
        in_uvlo <= 1'h1;
        tick(6);
        chk(boost_on, 1'h0);
        in_uvlo <= 1'h0;
        aresetn <= 1'h0;
        mode_freq_select_pin <= 1'h0;
        tick(5);
        aresetn <= 1'h1;
        enable_pin <= 1'h1;
        up;
        rd(12'h008, 32'h480);
        mode_freq_select_pin <= 1'h1;
        in_uvlo <= 1'h1;
        wr(12'h004, 32'h0);
        tick(6);
        chk(boost_on, 1'h1);
        rd(12'h008, 32'h480);
        in_uvlo <= 1'h0;
        current_limit <= 1'h1;
        tick(COC + 8);
        chk(ldo_on, 1'h0);
        current_limit <= 1'h0;
        rd(12'h008, 32'h582);
        enable_pin <= 1'h0;
        short_f <= 8'h04;
        tick(4);
        enable_pin <= 1'h1;
        up;
        tick(CSH + 4);
        chk(string_enable, 8'hb3);
        short_f <= 8'h0;
        enable_pin <= 1'h0;
        tick(6);
        chk(ldo_on, 1'h0);
        rd(12'h008, 32'h80);
        enable_pin <= 1'h1;
        up;
        open_f <= 8'hb7;
        tick(8);
        chk(boost_on, 1'h0);
        thermal_fault <= 1'h1;
        tick(6);
        chk(ldo_on, 1'h0);
        thermal_fault <= 1'h0;
        open_f <= 8'h0;
        rd(12'h008, 32'h582);
        finish_test;
    end
endmodule // led_seq_bench
